// *** rtl/stepper_lock.sv ***
`timescale 1ns/1ps
module stepper_lock
	import lock_pkg::*;
#(
	parameter int POS_W    = 24,
	parameter int CLK_HZ_P = CLK_HZ
)(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// Parameter write port
	input  wire logic              paramWrite,
	input  wire logic              controllerModeSelect,
	input  wire logic [15:0]       lockDelaySetting,
	input  wire logic [6:0]        holdingCurrentPercent,
	input  wire logic [1:0]        samplingPeriod,
	input  wire logic [15:0]       proportionalGain,
	input  wire logic [15:0]       derivativeGain,
	input  wire logic [15:0]       integralGain,
	input  wire logic [15:0]       idleIntegralGain,
	input  wire logic              encoderResolution1000,
	input  wire logic              saveParameterSet,
	// Positions and motion
	input  wire logic [POS_W-1:0]  referencePos,
	input  wire logic [POS_W-1:0]  measuredPos,
	input  wire logic [11:0]       positionWindow,
	input  wire logic              moveRequest,
	input  wire logic [12:0]       speedRequestRpm,
	input  wire logic [19:0]       stepFreqRequest,
	// Status and drive outputs
	output logic                   locked,
	output logic                   commutationEnable,
	output logic [6:0]             driveCurrentPercent,
	output logic                   loadAngleMode,
	output logic                   targetReached,
	output logic                   moveAccept,
	output logic [12:0]            speedCmdRpm,
	output logic [19:0]            stepFreqCmd,
	output logic                   saveStrobe,
	output logic [1:0]             activePeriod,
	output logic [15:0]            savedProportionalGain,
	output logic [15:0]            savedDerivativeGain,
	output logic [15:0]            savedIntegralGain,
	output logic [15:0]            savedIdleIntegralGain,
	output logic [1:0]             savedPeriod,
	output logic                   savedMode
);
	lock_state_e     state_reg, state_next;
	logic [15:0]     delay_reg, delay_next;
	logic [6:0]      hold_reg, hold_next;
	logic            mode_reg, mode_next;
	logic [1:0]      period_reg, period_next;
	logic [15:0]     dwell_reg, dwell_next;
	logic [POS_W-1:0] refPrev_reg;
	logic [1:0]      inWin_reg, inWin_next;
	logic            moving_reg, moving_next;
	logic            sampleTick, msTick;
	logic            refChanged, inFrame, inWindow;
	logic [POS_W-1:0] dev;
	logic [3:0]      frameWidth;
	logic [19:0]     freqCap;

	sample_tick #(
		.CLK_HZ_P (CLK_HZ_P)
	) u_tick (
		.ref_clk        (ref_clk),
		.rst            (rst),
		.samplingPeriod (period_reg),
		.sampleTick     (sampleTick),
		.msTick         (msTick)
	);

	always_comb
	begin
		dev        = (measuredPos >= referencePos) ? measuredPos - referencePos
		                                           : referencePos - measuredPos;
		frameWidth = encoderResolution1000 ? FRAME_1000 : FRAME_500; // see R4
		inFrame    = dev <= POS_W'(frameWidth);
		inWindow   = dev <= POS_W'(positionWindow);
		refChanged = referencePos != refPrev_reg;
	end

	// Parameters, with range clipping
	always_comb
	begin
		delay_next  = delay_reg;
		hold_next   = hold_reg;
		mode_next   = mode_reg;
		period_next = period_reg;
		if (paramWrite)
		begin
			mode_next   = controllerModeSelect; // see R1
			delay_next  = (lockDelaySetting > LOCK_DELAY_MAX) ? LOCK_DELAY_MAX
			                                                 : lockDelaySetting; // see R3
			hold_next   = (holdingCurrentPercent > HOLD_PCT_MAX) ? HOLD_PCT_MAX
			                                                    : holdingCurrentPercent; // see R19
			period_next = (samplingPeriod > PERIOD_2000US) ? PERIOD_1000US : samplingPeriod;
		end
	end

	// Lock state machine; dwell counts ms, checked on each sample tick
	always_comb
	begin
		state_next = state_reg;
		dwell_next = dwell_reg;
		if (msTick && dwell_reg != 16'hffff)
			dwell_next = dwell_reg + 16'd1;
		case (state_reg)
			ST_REGULATED:
			begin
				dwell_next = '0;
				if (sampleTick && delay_reg != '0 && inFrame && !refChanged) // see R2, R21
					state_next = ST_DWELL;
			end
			ST_DWELL:
			begin
				if (refChanged || delay_reg == '0)
					state_next = ST_REGULATED;
				else if (sampleTick) // see R21
				begin
					if (!inFrame)
						state_next = ST_REGULATED;
					else if (dwell_reg >= delay_reg)
						state_next = ST_LOCKED; // see R5, R3
				end
			end
			ST_LOCKED:
				if (refChanged || !inFrame || delay_reg == '0)
					state_next = ST_REGULATED; // see R6
			default:
				state_next = ST_REGULATED;
		endcase
	end

	// Target reached after consecutive in-window samples; moves gated on it
	always_comb
	begin
		inWin_next  = inWin_reg;
		moving_next = moving_reg;
		if (sampleTick)
			inWin_next = !inWindow ? 2'd0
			           : (inWin_reg == IN_WINDOW_PERIODS) ? inWin_reg : inWin_reg + 2'd1; // see R20
		if (refChanged)
			inWin_next = 2'd0;
		if (moveAccept)
			moving_next = 1'b1;
		else if (inWin_reg == IN_WINDOW_PERIODS)
			moving_next = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg   <= ST_REGULATED;
			delay_reg   <= LOCK_DELAY_RST;
			hold_reg    <= HOLD_PCT_RST;
			mode_reg    <= MODE_RST;
			period_reg  <= PERIOD_RST;
			dwell_reg   <= '0;
			refPrev_reg <= '0;
			inWin_reg   <= '0;
			moving_reg  <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			delay_reg   <= delay_next;
			hold_reg    <= hold_next;
			mode_reg    <= mode_next;
			period_reg  <= period_next;
			dwell_reg   <= dwell_next;
			refPrev_reg <= referencePos;
			inWin_reg   <= inWin_next;
			moving_reg  <= moving_next;
		end
	end

	// Saved parameter set
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			saveStrobe            <= 1'b0;
			savedProportionalGain <= PGAIN_RST;
			savedDerivativeGain   <= DGAIN_RST;
			savedIntegralGain     <= IGAIN_RST;
			savedIdleIntegralGain <= IDLE_IGAIN_RST;
			savedPeriod           <= PERIOD_RST;
			savedMode             <= MODE_RST;
		end
		else
		begin
			saveStrobe <= saveParameterSet;
			if (saveParameterSet) // see R18
			begin
				savedProportionalGain <= proportionalGain;
				savedDerivativeGain   <= derivativeGain;
				savedIntegralGain     <= integralGain;
				savedIdleIntegralGain <= idleIntegralGain;
				savedPeriod           <= period_reg;
				savedMode             <= mode_reg;
			end
		end
	end

	// Limits are combinational clamps so a request never passes through uncapped
	always_comb
	begin
		freqCap             = encoderResolution1000 ? MAX_FREQ_1000_HZ : MAX_FREQ_500_HZ;
		stepFreqCmd         = (stepFreqRequest > freqCap) ? freqCap : stepFreqRequest; // see R10
		speedCmdRpm         = (speedRequestRpm > MAX_RPM) ? MAX_RPM : speedRequestRpm; // see R9
		locked              = state_reg == ST_LOCKED;
		commutationEnable   = !locked; // see R7
		driveCurrentPercent = locked ? hold_reg : FULL_PCT; // see R7
		loadAngleMode       = mode_reg == CTRL_LOAD_ANGLE; // see R1
		targetReached       = inWin_reg == IN_WINDOW_PERIODS;
		moveAccept          = moveRequest && !moving_reg; // see R15
		activePeriod        = period_reg;
	end

	a_zero_no_lock: assert property (@(posedge ref_clk) disable iff (rst)
		delay_reg == '0 |=> state_reg != ST_LOCKED) // see R2
		else $error("locked with zero delay");
	a_unlock_refchg: assert property (@(posedge ref_clk) disable iff (rst)
		locked && refChanged |=> !locked) // see R6
		else $error("no unlock on setpoint change");
	a_unlock_frame: assert property (@(posedge ref_clk) disable iff (rst)
		locked && !inFrame |=> !locked) // see R6
		else $error("no unlock on frame exit");
	a_hold_current: assert property (@(posedge ref_clk) disable iff (rst)
		locked |-> !commutationEnable && driveCurrentPercent == hold_reg) // see R7
		else $error("locked drive wrong");
	a_speed_cap: assert property (@(posedge ref_clk) disable iff (rst)
		speedCmdRpm <= MAX_RPM) // see R9
		else $error("speed over cap");
	a_freq_cap: assert property (@(posedge ref_clk) disable iff (rst)
		stepFreqCmd <= (encoderResolution1000 ? MAX_FREQ_1000_HZ : MAX_FREQ_500_HZ)) // see R10
		else $error("step frequency over cap");
	a_move_gate: assert property (@(posedge ref_clk) disable iff (rst)
		moveAccept |=> !moveAccept) // see R15
		else $error("move accepted before window");

	sequence s_lock_rise;
		!locked ##1 locked;
	endsequence

	a_lock_dwell: assert property (@(posedge ref_clk) disable iff (rst)
		s_lock_rise |-> $past(dwell_reg) >= delay_reg && $past(inFrame)) // see R3, R5
		else $error("locked before dwell");
	a_save_set: assert property (@(posedge ref_clk) disable iff (rst)
		saveParameterSet |=> saveStrobe && savedProportionalGain == $past(proportionalGain)) // see R18
		else $error("save missed");
	a_mode_sel: assert property (@(posedge ref_clk) disable iff (rst)
		paramWrite |=> loadAngleMode == $past(controllerModeSelect)) // see R1
		else $error("mode not taken");
endmodule // stepper_lock

// *** rtl/lock_pkg.sv ***
// How it works
// R1 - Mode 0 current, 1 load angle controller
// R2 - Lock delay zero never locks, default
// R3 - Delay 1..32767 ms dwell before locking
// R4 - Frame 8 increments (1000), 4 (500)
// R5 - Nonzero delay locks automatically on dwell
// R6 - Setpoint change or frame exit unlocks immediately
// R7 - Locked: stop commutation, hold, holding current
// R8 - Host tunes gains only while unlocked
// R9 - Commanded speed capped at 5850 rpm
// R10 - Step frequency 195 or 390 kHz
// R11 - Host keeps derivative 3..12 times proportional
// R12 - Host starts derivative at seven times proportional
// R13 - Host keeps integral below proportional/50
// R14 - Host sets idle integral when integral zero
// R15 - Point-to-point holds commands until in window
// R16 - Host: proportional above 1000 needs period 500
// R17 - Host retunes after controller mode change
// R18 - Save command stores current parameter set
// R19 - Holding current 0..100 percent, default 50
// R20 - Target reached after two in-window periods
// R21 - Evaluate dwell and lock each sampling period
package lock_pkg;
	localparam int          CLK_HZ           = 100000000;
	localparam int          MS_CYCLES        = CLK_HZ / 1000;
	localparam int          US_CYCLES        = CLK_HZ / 1000000;
	localparam logic [15:0] LOCK_DELAY_RST   = 16'h0000;
	localparam logic [15:0] LOCK_DELAY_MAX   = 16'h7fff;
	localparam logic [6:0]  HOLD_PCT_RST     = 7'h32;
	localparam logic [6:0]  HOLD_PCT_MAX     = 7'h64;
	localparam logic [6:0]  FULL_PCT         = 7'h64;
	localparam logic [3:0]  FRAME_1000       = 4'h8;
	localparam logic [3:0]  FRAME_500        = 4'h4;
	localparam logic [1:0]  IN_WINDOW_PERIODS = 2'h2;
	localparam logic [12:0] MAX_RPM          = 13'h16da;
	localparam logic [19:0] MAX_FREQ_500_HZ  = 20'h2f9b8;
	localparam logic [19:0] MAX_FREQ_1000_HZ = 20'h5f370;
	localparam logic [1:0]  PERIOD_500US     = 2'h0;
	localparam logic [1:0]  PERIOD_1000US    = 2'h1;
	localparam logic [1:0]  PERIOD_2000US    = 2'h2;
	localparam logic [15:0] PGAIN_RST        = 16'h00c8;
	localparam logic [15:0] DGAIN_RST        = 16'h0578;
	localparam logic [15:0] IGAIN_RST        = 16'h0000;
	localparam logic [15:0] IDLE_IGAIN_RST   = 16'h0001;
	localparam logic        MODE_RST         = 1'b0;
	localparam logic [1:0]  PERIOD_RST       = PERIOD_1000US;
	typedef enum logic [0:0] {CTRL_CURRENT, CTRL_LOAD_ANGLE} ctrl_mode_e;
	typedef enum {ST_REGULATED, ST_DWELL, ST_LOCKED} lock_state_e;

	// Sampling period length in clock cycles
	function automatic logic [17:0] periodCycles(input logic [1:0] sel, input int usCycles);
		case (sel)
			PERIOD_500US:  periodCycles = 18'(500 * usCycles);
			PERIOD_2000US: periodCycles = 18'(2000 * usCycles);
			default:       periodCycles = 18'(1000 * usCycles);
		endcase
	endfunction
endpackage

// *** rtl/sample_tick.sv ***
`timescale 1ns/1ps
module sample_tick
	import lock_pkg::*;
#(
	parameter int CLK_HZ_P = CLK_HZ
)(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Period select and tick
	input  wire logic [1:0] samplingPeriod,
	output logic            sampleTick,
	output logic            msTick
);
	// Tick lengths follow the clock rate so both ticks stay in real time
	localparam int US_N = CLK_HZ_P / 1000000;
	localparam int MS_N = CLK_HZ_P / 1000;

	logic [17:0] periodCnt_reg, periodCnt_next;
	logic [16:0] msCnt_reg,     msCnt_next;

	always_comb
	begin
		sampleTick     = (periodCnt_reg >= periodCycles(samplingPeriod, US_N) - 18'd1);
		periodCnt_next = sampleTick ? 18'd0 : periodCnt_reg + 18'd1;
		msTick         = (msCnt_reg == 17'(MS_N - 1));
		msCnt_next     = msTick ? 17'd0 : msCnt_reg + 17'd1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			periodCnt_reg <= '0;
			msCnt_reg     <= '0;
		end
		else
		begin
			periodCnt_reg <= periodCnt_next;
			msCnt_reg     <= msCnt_next;
		end
	end
endmodule // sample_tick

// *** tb/motor_model.sv ***
`timescale 1ns/1ps
module motor_model #(
	parameter int POS_W = 24
)(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Setpoint and external load
	input  wire logic [POS_W-1:0] referencePos,
	input  wire logic [POS_W-1:0] loadOffset,
	// Encoder reading, 4-fold increments
	output logic      [POS_W-1:0] measuredPos
);
	// Shaft follows the setpoint one clock cycle late; a load pushes it off by loadOffset
	always_ff @(posedge ref_clk)
	begin
		measuredPos <= rst ? referencePos : referencePos + loadOffset;
	end
endmodule // motor_model

// *** tb/tb_stepper_lock.sv ***
`timescale 1ns/1ps
module tb_stepper_lock
	import lock_pkg::*;
;
	logic        ref_clk = 0, rst = 1, paramWrite = 0, modeSel = 0, enc1000 = 1, save = 0;
	logic        moveRequest = 0, locked, commutationEnable, loadAngleMode, targetReached;
	logic        moveAccept, saveStrobe, savedMode;
	logic [15:0] delay = 0, pGain = 0, dGain = 0, iGain = 0, idleGain = 0;
	logic [15:0] savedP, savedD, savedI, savedIdle;
	logic [6:0]  holdPct = 0, drivePct;
	logic [1:0]  period = 1, activePeriod, savedPeriod;
	logic [23:0] refPos = 24'h000100, measPos, loadOffset = 0;
	logic [12:0] rpmReq = 0, rpmCmd;
	logic [19:0] freqReq = 0, freqCmd;
	int          nMismatch = 0, cmpCount = 0;

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	motor_model i_motor (.ref_clk(ref_clk), .rst(rst), .referencePos(refPos),
		.loadOffset(loadOffset), .measuredPos(measPos));

	// Scaled clock rate keeps the ms dwell and sampling periods short
	stepper_lock #(.CLK_HZ_P(1000000)) i_dut (.ref_clk(ref_clk), .rst(rst), .paramWrite(paramWrite),
		.controllerModeSelect(modeSel), .lockDelaySetting(delay),
		.holdingCurrentPercent(holdPct), .samplingPeriod(period), .proportionalGain(pGain),
		.derivativeGain(dGain), .integralGain(iGain), .idleIntegralGain(idleGain),
		.encoderResolution1000(enc1000), .saveParameterSet(save), .referencePos(refPos),
		.measuredPos(measPos), .positionWindow(12'h00a), .moveRequest(moveRequest),
		.speedRequestRpm(rpmReq), .stepFreqRequest(freqReq), .locked(locked),
		.commutationEnable(commutationEnable), .driveCurrentPercent(drivePct),
		.loadAngleMode(loadAngleMode), .targetReached(targetReached), .moveAccept(moveAccept),
		.speedCmdRpm(rpmCmd), .stepFreqCmd(freqCmd), .saveStrobe(saveStrobe),
		.activePeriod(activePeriod), .savedProportionalGain(savedP),
		.savedDerivativeGain(savedD), .savedIntegralGain(savedI),
		.savedIdleIntegralGain(savedIdle), .savedPeriod(savedPeriod), .savedMode(savedMode));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (nMismatch == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic write_params(input logic m, input logic [15:0] d, input logic [6:0] h,
		input logic [1:0] p);
		@(posedge ref_clk);
		paramWrite <= 1;
		modeSel <= m;
		delay <= d;
		holdPct <= h;
		period <= p;
		@(posedge ref_clk);
		paramWrite <= 0;
		#1;
	endtask

	task automatic reset_values();
		chk("locked", locked, 0);
		chk("commutation", commutationEnable, 1);
		chk("drive", drivePct, FULL_PCT);
		chk("mode", loadAngleMode, MODE_RST);
		chk("savedP", savedP, PGAIN_RST);
		chk("savedD", savedD, DGAIN_RST);
		chk("savedIdle", savedIdle, IDLE_IGAIN_RST);
	endtask

	task automatic mode_select();
		write_params(1, 0, 7'h32, 2);
		chk("mode1", loadAngleMode, 1);
		chk("period", activePeriod, PERIOD_2000US);
		write_params(0, 0, 7'h32, 0);
		chk("mode0", loadAngleMode, 0);
	endtask

	task automatic clamps();
		@(posedge ref_clk);
		rpmReq <= 13'h1fff;
		freqReq <= 20'hfffff;
		enc1000 <= 0;
		#1;
		chk("rpmMax", rpmCmd, MAX_RPM);
		chk("freq500", freqCmd, MAX_FREQ_500_HZ);
		@(posedge ref_clk);
		rpmReq <= 13'h16d9;
		freqReq <= 20'h5f371;
		enc1000 <= 1;
		#1;
		chk("rpmPass", rpmCmd, 13'h16d9);
		chk("freq1000", freqCmd, MAX_FREQ_1000_HZ);
	endtask

	task automatic save_set();
		@(posedge ref_clk);
		save <= 1;
		pGain <= 16'h012c;
		dGain <= 16'h0834;
		iGain <= 16'h0006;
		idleGain <= 16'h0002;
		@(posedge ref_clk);
		save <= 0;
		#1;
		chk("strobe", saveStrobe, 1);
		chk("savedP", savedP, 16'h012c);
		chk("savedD", savedD, 16'h0834);
		chk("savedI", savedI, 16'h0006);
		chk("savedIdle", savedIdle, 16'h0002);
		chk("savedPeriod", savedPeriod, PERIOD_500US);
		chk("savedMode", savedMode, 0);
		cyc(1);
		chk("strobeEnd", saveStrobe, 0);
	endtask

	task automatic lock_and_release();
		int i;
		@(posedge ref_clk);
		moveRequest <= 1;
		#1;
		chk("accept", moveAccept, 1);
		cyc(1);
		chk("holdOff", moveAccept, 0);
		moveRequest <= 0;
		// Short delay keeps the dwell to a few sample periods at 500 us
		write_params(0, 16'h0001, 7'h1e, 0);
		for (i = 0; i < 20000 && locked !== 1'b1; i++)
			cyc(1);
		if (locked !== 1'b1)
		begin
			nMismatch++;
			tally_and_finish();
		end
		chk("lockDrive", drivePct, 7'h1e);
		chk("lockComm", commutationEnable, 0);
		chk("target", targetReached, 1);
		moveRequest <= 1;
		#1;
		chk("acceptAgain", moveAccept, 1);
		@(posedge ref_clk);
		moveRequest <= 0;
		loadOffset <= 24'h000008;
		cyc(4);
		chk("frameEdge", locked, 1);
		loadOffset <= 24'h000009;
		cyc(3);
		chk("unlocked", locked, 0);
		chk("unlockDrive", drivePct, FULL_PCT);
		chk("unlockComm", commutationEnable, 1);
		loadOffset <= 0;
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		cyc(1);
		reset_values();
		mode_select();
		clamps();
		save_set();
		lock_and_release();
		tally_and_finish();
	end
endmodule // tb_stepper_lock
